//--- hw/ccr_params.svh
// register offsets, field positions, reset values and bus address for the charger config bank
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH

`define CCR_DEV_ADDR        7'h6b
`define CCR_NUM_REGS        8
`define CCR_PTR_W           4
`define CCR_ADDR_W          3

`define CCR_OFS_INPUT_SRC   3'h0
`define CCR_OFS_POWER_ON    3'h1
`define CCR_OFS_CHG_CURRENT 3'h2
`define CCR_OFS_PRECHG_TERM 3'h3
`define CCR_OFS_CHG_VOLT    3'h4
`define CCR_OFS_TERM_TIMER  3'h5
`define CCR_OFS_BOOST_THERM 3'h6
`define CCR_OFS_MISC        3'h7

`define CCR_RST_INPUT_SRC   8'h58
`define CCR_RST_POWER_ON    8'h3b
`define CCR_RST_CHG_CURRENT 8'h20
`define CCR_RST_PRECHG_TERM 8'h11
`define CCR_RST_CHG_VOLT    8'hb2
`define CCR_RST_TERM_TIMER  8'h9c
`define CCR_RST_BOOST_THERM 8'h93
`define CCR_RST_MISC        8'h00

// power_on_configuration fields
`define CCR_POC_REG_RESET   7
`define CCR_POC_WDT_RESTART 6
`define CCR_POC_BOOST_EN    5
`define CCR_POC_CHG_EN      4
`define CCR_POC_SYSMIN_HI   3
`define CCR_POC_SYSMIN_LO   1

// charge_current_control fields
`define CCR_CCC_FAST_HI     7
`define CCR_CCC_FAST_LO     2
`define CCR_CCC_COLD_SEL    1
`define CCR_CCC_REDUCED     0

// precharge_termination_control fields
`define CCR_PTC_PRECHG_HI   7
`define CCR_PTC_PRECHG_LO   4

`define CCR_BIT_CNT_W       4
`define CCR_BITS_PER_BYTE   4'h8
`define CCR_LAST_BIT        4'h7

`endif

//--- hw/ccr_pkg.sv
// types shared by the charger config bank modules
package ccr_pkg;

  typedef logic [7:0] ccr_byte_t;

  typedef enum logic [2:0] {
    CCR_IDLE,
    CCR_DEV_ADDR,
    CCR_REG_ADDR,
    CCR_WR_DATA,
    CCR_ACK,
    CCR_RD_DATA,
    CCR_HOST_ACK,
    CCR_RD_LOAD
  } ccr_state_t;

endpackage

//--- hw/ccr_regbank.sv
// eight byte register bank with defaults, soft register reset and self-clearing strobes
`timescale 1ns/1ps
`include "ccr_params.svh"
module ccr_regbank (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  ccr_regif.bank   rif
);
  import ccr_pkg::*;

  localparam ccr_byte_t DEF [`CCR_NUM_REGS] = '{
    `CCR_RST_INPUT_SRC, `CCR_RST_POWER_ON, `CCR_RST_CHG_CURRENT, `CCR_RST_PRECHG_TERM,
    `CCR_RST_CHG_VOLT, `CCR_RST_TERM_TIMER, `CCR_RST_BOOST_THERM, `CCR_RST_MISC};

  ccr_byte_t mem_q [`CCR_NUM_REGS];
  ccr_byte_t mem_d [`CCR_NUM_REGS];
  ccr_byte_t rdata_q;
  ccr_byte_t rdata_d;
  logic      wdt_q;
  logic      wdt_d;
  logic      soft_rst;
  logic      poc_wr;

  assign poc_wr   = rif.wr && (rif.waddr == `CCR_OFS_POWER_ON);
  assign soft_rst = poc_wr && rif.wdata[`CCR_POC_REG_RESET];

  ////////////////////////////////////////////////////////////////////////////////
  genvar g;
  for (g = 0; g < `CCR_NUM_REGS; g++) begin : g_entry
    always_comb begin
      mem_d[g] = mem_q[g];
      if (soft_rst) begin
        mem_d[g] = DEF[g];
      end else if (rif.wr && rif.waddr == 3'(g)) begin
        mem_d[g] = rif.wdata;
        if (3'(g) == `CCR_OFS_POWER_ON) begin
          // strobe bits never stick, so a later read returns zero
          mem_d[g][`CCR_POC_REG_RESET]   = 1'b0;
          mem_d[g][`CCR_POC_WDT_RESTART] = 1'b0;
        end
      end
    end
    always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
        mem_q[g] <= DEF[g];
      end else begin
        mem_q[g] <= mem_d[g];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rdata_d = mem_q[rif.raddr];
    // a soft reset writes only register contents; the restart pulse is suppressed with it
    wdt_d   = poc_wr && !soft_rst && rif.wdata[`CCR_POC_WDT_RESTART];
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rdata_q <= 8'h00;
      wdt_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      wdt_q   <= wdt_d;
    end
  end

  assign rif.rdata       = rdata_q;
  assign rif.poc         = mem_q[`CCR_OFS_POWER_ON];
  assign rif.ccc         = mem_q[`CCR_OFS_CHG_CURRENT];
  assign rif.ptc         = mem_q[`CCR_OFS_PRECHG_TERM];
  assign rif.wdt_restart = wdt_q;
endmodule // ccr_regbank

//--- hw/ccr_regif.sv
// link between the serial engine and the register bank
`timescale 1ns/1ps
interface ccr_regif;
  import ccr_pkg::*;
  logic        wr;
  logic [2:0]  waddr;
  ccr_byte_t   wdata;
  logic [2:0]  raddr;
  ccr_byte_t   rdata;
  ccr_byte_t   poc;
  ccr_byte_t   ccc;
  ccr_byte_t   ptc;
  logic        wdt_restart;

  modport engine (output wr, waddr, wdata, raddr,
                  input  rdata, poc, ccc, ptc, wdt_restart);
  modport bank   (input  wr, waddr, wdata, raddr,
                  output rdata, poc, ccc, ptc, wdt_restart);
endinterface

//--- hw/ccr_top.sv
// two-wire serial slave in front of the charger configuration and current registers
`timescale 1ns/1ps
`include "ccr_params.svh"
// Contract
// - writing one to register reset restores defaults
// - soft reset touches registers, not operating mode
// - writing one restarts the watchdog, default zero
// - boost enable bit, default on
// - boost enable overrides charge enable
// - charge enable bit, default on
// - min system voltage code bits 3..1, default 101
// - fast charge code bits 7..2, default 001000
// - cold threshold select, default zero
// - reduced current force scales fast and precharge; the code only passes the bit out on o_reduced_current_force
// - power-on configuration resets to 0x3b
// - charge current control resets to 0x20
// - serial bus address 6bh, registers 0..7 writable
module ccr_top (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda_o,
  output logic      o_sda_oe,
  output logic      o_scl_o,
  output logic      o_scl_oe,
  output logic      o_boost_output_enable,
  output logic      o_charge_enable,
  output logic [2:0] o_min_system_voltage,
  output logic [5:0] o_fast_charge_current,
  output logic [3:0] o_precharge_current,
  output logic      o_cold_threshold_sel,
  output logic      o_reduced_current_force,
  output logic      o_wdt_restart
);
  import ccr_pkg::*;

  ccr_regif rif ();

  ccr_regbank u_bank (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .rif       (rif)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // line sampling and bus conditions
  logic scl_q;
  logic scl_d;
  logic sda_q;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  always_comb begin
    scl_d = i_scl;
    sda_d = i_sda;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_d;
      sda_q <= sda_d;
    end
  end

  assign scl_rise = i_scl && !scl_q;
  assign scl_fall = !i_scl && scl_q;
  assign start_c  = i_scl && scl_q && sda_q && !i_sda;
  assign stop_c   = i_scl && scl_q && !sda_q && i_sda;

  ////////////////////////////////////////////////////////////////////////////////
  // byte engine
  ccr_state_t                st_q;
  ccr_state_t                st_d;
  ccr_state_t                after_q;
  ccr_state_t                after_d;
  ccr_byte_t                 sh_q;
  ccr_byte_t                 sh_d;
  logic [`CCR_BIT_CNT_W-1:0] cnt_q;
  logic [`CCR_BIT_CNT_W-1:0] cnt_d;
  logic [`CCR_PTR_W-1:0]     ptr_q;
  logic [`CCR_PTR_W-1:0]     ptr_d;
  logic                      oe_q;
  logic                      oe_d;
  logic                      wr_d;
  logic                      ptr_ok;

  // pointer past the last writable register means the byte is refused
  assign ptr_ok = (ptr_q < `CCR_PTR_W'(`CCR_NUM_REGS));

  always_comb begin
    st_d    = st_q;
    after_d = after_q;
    sh_d    = sh_q;
    cnt_d   = cnt_q;
    ptr_d   = ptr_q;
    oe_d    = oe_q;
    wr_d    = 1'b0;
    case (st_q)
      CCR_IDLE: begin
      end
      CCR_DEV_ADDR, CCR_REG_ADDR, CCR_WR_DATA: begin
        if (scl_rise && cnt_q != `CCR_BITS_PER_BYTE) begin
          sh_d  = {sh_q[6:0], i_sda};
          cnt_d = cnt_q + `CCR_BIT_CNT_W'(1);
        end else if (scl_fall && cnt_q == `CCR_BITS_PER_BYTE) begin
          st_d = CCR_IDLE; // unmatched address or register: no ack, wait for start
          if (st_q == CCR_DEV_ADDR && sh_q[7:1] == `CCR_DEV_ADDR) begin
            oe_d    = 1'b1;
            st_d    = CCR_ACK;
            after_d = sh_q[0] ? CCR_RD_DATA : CCR_REG_ADDR;
          end else if (st_q == CCR_REG_ADDR && sh_q < 8'(`CCR_NUM_REGS)) begin
            ptr_d   = sh_q[`CCR_PTR_W-1:0];
            oe_d    = 1'b1;
            st_d    = CCR_ACK;
            after_d = CCR_WR_DATA;
          end else if (st_q == CCR_WR_DATA && ptr_ok) begin
            wr_d    = 1'b1;
            ptr_d   = ptr_q + `CCR_PTR_W'(1);
            oe_d    = 1'b1;
            st_d    = CCR_ACK;
            after_d = CCR_WR_DATA;
          end
        end
      end
      CCR_ACK, CCR_RD_LOAD: begin
        if (scl_fall) begin
          cnt_d = '0;
          oe_d  = 1'b0;
          st_d  = after_q;
          if (after_q == CCR_RD_DATA || st_q == CCR_RD_LOAD) begin
            // reads past the bank return zero rather than stalling the host
            sh_d = ptr_ok ? rif.rdata : 8'h00;
            oe_d = !sh_d[7];
            st_d = CCR_RD_DATA;
          end
        end
      end
      CCR_RD_DATA: begin
        if (scl_fall) begin
          if (cnt_q == `CCR_LAST_BIT) begin
            oe_d = 1'b0;
            st_d = CCR_HOST_ACK;
          end else begin
            sh_d  = {sh_q[6:0], 1'b0};
            cnt_d = cnt_q + `CCR_BIT_CNT_W'(1);
            oe_d  = !sh_d[7];
          end
        end
      end
      CCR_HOST_ACK: begin
        if (scl_rise) begin
          if (i_sda) begin
            st_d = CCR_IDLE;
          end else begin
            ptr_d = ptr_q + `CCR_PTR_W'(1);
            st_d  = CCR_RD_LOAD;
          end
        end
      end
      default: begin
        st_d = CCR_IDLE;
      end
    endcase
    // bus conditions win over any bit in flight
    if (start_c) begin
      st_d  = CCR_DEV_ADDR;
      cnt_d = '0;
      oe_d  = 1'b0;
      wr_d  = 1'b0;
    end else if (stop_c) begin
      st_d = CCR_IDLE;
      oe_d = 1'b0;
      wr_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st_q    <= CCR_IDLE;
      after_q <= CCR_IDLE;
      sh_q    <= 8'h00;
      cnt_q   <= '0;
      ptr_q   <= '0;
      oe_q    <= 1'b0;
    end else begin
      st_q    <= st_d;
      after_q <= after_d;
      sh_q    <= sh_d;
      cnt_q   <= cnt_d;
      ptr_q   <= ptr_d;
      oe_q    <= oe_d;
    end
  end

  assign rif.wr    = wr_d;
  assign rif.waddr = ptr_q[`CCR_ADDR_W-1:0];
  assign rif.wdata = sh_q;
  // the bank read port follows the pointer; scl timing leaves ample cycles to settle
  assign rif.raddr = ptr_q[`CCR_ADDR_W-1:0];

  ////////////////////////////////////////////////////////////////////////////////
  // regulation controls; soft reset reloads these and leaves the engine state alone
  logic ovr_chg_q;
  logic ovr_chg_d;

  always_comb begin
    // boost owns the power stage, so it masks the charge request
    ovr_chg_d = rif.poc[`CCR_POC_CHG_EN] && !rif.poc[`CCR_POC_BOOST_EN];
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ovr_chg_q <= 1'b0;
    end else begin
      ovr_chg_q <= ovr_chg_d;
    end
  end

  assign o_sda_o                 = 1'b0;
  assign o_sda_oe                = oe_q;
  assign o_scl_o                 = 1'b0;
  assign o_scl_oe                = 1'b0;
  assign o_boost_output_enable   = rif.poc[`CCR_POC_BOOST_EN];
  assign o_charge_enable         = ovr_chg_q;
  assign o_min_system_voltage    = rif.poc[`CCR_POC_SYSMIN_HI:`CCR_POC_SYSMIN_LO];
  assign o_fast_charge_current   = rif.ccc[`CCR_CCC_FAST_HI:`CCR_CCC_FAST_LO];
  assign o_precharge_current     = rif.ptc[`CCR_PTC_PRECHG_HI:`CCR_PTC_PRECHG_LO];
  assign o_cold_threshold_sel    = rif.ccc[`CCR_CCC_COLD_SEL];
  assign o_reduced_current_force = rif.ccc[`CCR_CCC_REDUCED];
  assign o_wdt_restart           = rif.wdt_restart;
endmodule // ccr_top

//--- test/ccr_host_model.sv
// two-wire host model driving the charger register bank
`timescale 1ns/1ps
`include "ccr_params.svh"
module ccr_host_model (
  input  wire logic i_clk_sys,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  // four clocks a phase stays above the three-clock minimum; a one releases the line
  task automatic clk_bit(input logic b, output logic s);
    tick(1);
    o_sda = b;
    tick(3);
    o_scl = 1'b1;
    tick(2);
    s = i_sda;
    tick(2);
    o_scl = 1'b0;
  endtask
  task automatic start();
    tick(1);
    o_sda = 1'b1;
    tick(3);
    o_scl = 1'b1;
    tick(4);
    o_sda = 1'b0;
    tick(4);
    o_scl = 1'b0;
  endtask
  task automatic stop();
    tick(1);
    o_sda = 1'b0;
    tick(3);
    o_scl = 1'b1;
    tick(4);
    o_sda = 1'b1;
    tick(4);
  endtask
  task automatic send(input logic [7:0] d, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'b1, nack);
  endtask
  // n data bytes, high byte of dt first; any refused byte shows as a nack
  task automatic wr(input logic [6:0] dev, input logic [7:0] rg, input logic [15:0] dt,
                    input int n, output logic nack);
    logic a0, a1, a2;
    start();
    send({dev, 1'b0}, a0);
    send(rg, a1);
    nack = a0 | a1;
    for (int j = n - 1; j >= 0; j--) begin
      send(dt[8*j +: 8], a2);
      nack = nack | a2;
    end
    stop();
  endtask
  task automatic rd(input logic [7:0] rg, input int n, output logic [15:0] dt,
                    output logic nack);
    logic a0, a1, a2, s;
    start();
    send({`CCR_DEV_ADDR, 1'b0}, a0);
    send(rg, a1);
    start();
    send({`CCR_DEV_ADDR, 1'b1}, a2);
    for (int j = n - 1; j >= 0; j--) begin
      for (int i = 7; i >= 0; i--) begin
        clk_bit(1'b1, dt[8*j+i]);
      end
      // ack every byte but the last, whose nack ends the read
      clk_bit(j == 0, s);
    end
    stop();
    nack = a0 | a1 | a2;
  endtask
endmodule // ccr_host_model

//--- test/ccr_top_properties.sv
// concurrent checks on the charger config bank ports
`timescale 1ns/1ps
module ccr_top_properties (
  input wire logic       i_clk_sys,
  input wire logic       i_rst_n,
  input wire logic       i_scl,
  input wire logic       o_sda_o,
  input wire logic       o_sda_oe,
  input wire logic       o_scl_oe,
  input wire logic       o_boost_output_enable,
  input wire logic       o_charge_enable,
  input wire logic [2:0] o_min_system_voltage,
  input wire logic [5:0] o_fast_charge_current,
  input wire logic       o_cold_threshold_sel,
  input wire logic       o_reduced_current_force,
  input wire logic       o_wdt_restart
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////
  sequence s_quiet_start;
    !o_sda_oe ##1 !o_sda_oe;
  endsequence
  sequence s_ack_soon;
    ##[0:3] o_sda_oe;
  endsequence
  chk_reset_defaults: assert property ($rose(i_rst_n) |->
    o_boost_output_enable && !o_charge_enable && o_min_system_voltage == 3'h5 &&
    o_fast_charge_current == 6'h08 && !o_cold_threshold_sel && !o_reduced_current_force)
    else $error("outputs not at defaults after reset");
  chk_release_idle: assert property ($rose(i_rst_n) |-> s_quiet_start)
    else $error("data line pulled right after reset");
  chk_boost_priority: assert property (o_boost_output_enable |=> !o_charge_enable)
    else $error("charge enabled while boost on");
  chk_wdt_pulse: assert property (o_wdt_restart |=> !o_wdt_restart)
    else $error("restart pulse longer than one cycle");
  // a restart may only come from an acknowledged data byte
  chk_wdt_in_ack: assert property (o_wdt_restart |-> s_ack_soon)
    else $error("restart pulse outside a write acknowledge");
  chk_sda_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data line changed while clock high");
  chk_oe_hold: assert property ($rose(o_sda_oe) |=> o_sda_oe [*4])
    else $error("data line drive too short");
  chk_fields_scl_low: assert property ($changed({o_boost_output_enable,
    o_min_system_voltage, o_fast_charge_current, o_cold_threshold_sel,
    o_reduced_current_force}) |-> !i_scl)
    else $error("field changed outside a written byte");
  chk_no_stretch: assert property (!o_scl_oe && !o_sda_o)
    else $error("clock line driven or data driven high");
endmodule // ccr_top_properties

bind ccr_top ccr_top_properties u_ccr_props (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_scl(i_scl), .o_sda_o(o_sda_o),
  .o_sda_oe(o_sda_oe), .o_scl_oe(o_scl_oe), .o_boost_output_enable(o_boost_output_enable),
  .o_charge_enable(o_charge_enable), .o_min_system_voltage(o_min_system_voltage),
  .o_fast_charge_current(o_fast_charge_current), .o_cold_threshold_sel(o_cold_threshold_sel),
  .o_reduced_current_force(o_reduced_current_force), .o_wdt_restart(o_wdt_restart));

//--- test/ccr_top_tb.sv
// self-checking bench for the charger configuration and current registers
`timescale 1ns/1ps
`include "ccr_params.svh"
module ccr_top_tb;
  import ccr_pkg::*;
  typedef struct packed {
    logic [7:0]  rg;
    ccr_byte_t   dt;
    logic [16:0] outs;
  } ccr_row_t;
  logic        clk, rst_n, host_scl, host_sda, nack;
  logic        sda_o, sda_oe, scl_o, scl_oe, boost, chg, cold, frc, wdt;
  logic [2:0]  sysmin;
  logic [5:0]  fast;
  logic [3:0]  pre;
  logic [15:0] rd_val;
  int          failures = 0;
  int          compares = 0;
  int          wdt_cnt = 0;
  wire logic   sda_line = host_sda & ~sda_oe;
  wire logic   scl_line = host_scl & ~scl_oe;
  wire logic [16:0] outs = {boost, chg, sysmin, fast, pre, cold, frc};
  // register, value, expected {boost, chg, sysmin, fast, pre, cold, force}; 9e gives fast code 100111 with cold select set
  ccr_row_t    rows [6] = '{
    '{8'h02, 8'h9e, 17'h159c6}, '{8'h02, 8'h01, 17'h15005},
    '{8'h01, 8'h1a, 17'h0d005}, '{8'h01, 8'h0e, 17'h07005},
    '{8'h03, 8'hf0, 17'h0703d}, '{8'h01, 8'h31, 17'h1003d}};
  ccr_top uut (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_scl(scl_line), .i_sda(sda_line),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_scl_o(scl_o), .o_scl_oe(scl_oe),
    .o_boost_output_enable(boost), .o_charge_enable(chg), .o_min_system_voltage(sysmin),
    .o_fast_charge_current(fast), .o_precharge_current(pre), .o_cold_threshold_sel(cold),
    .o_reduced_current_force(frc), .o_wdt_restart(wdt));
  ccr_host_model host (.i_clk_sys(clk), .i_sda(sda_line), .o_scl(host_scl), .o_sda(host_sda));
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wdt === 1'b1) wdt_cnt <= wdt_cnt + 1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string nm, input logic [16:0] seen, input logic [16:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] rg, input ccr_byte_t dt);
    host.wr(`CCR_DEV_ADDR, rg, {8'h00, dt}, 1, nack);
    check("write ack", nack, 1'b0);
  endtask
  task automatic rd_chk(input logic [7:0] rg, input ccr_byte_t exp);
    host.rd(rg, 1, rd_val, nack);
    check("read ack", nack, 1'b0);
    check("read data", rd_val[7:0], exp);
  endtask
  task automatic summarize();
    if (failures == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #2000000;
    failures++;
    summarize();
  end
  initial begin
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    tick(2);
    check("defaults", outs, 17'h15204);
    check("line drive", {sda_o, scl_o, scl_oe}, 3'h0);
    rd_chk(8'h01, 8'h3b);
    rd_chk(8'h02, 8'h20);
    foreach (rows[i]) begin
      wr(rows[i].rg, rows[i].dt);
      check("fields", outs, rows[i].outs);
      rd_chk(rows[i].rg, rows[i].dt);
    end
    check("restarts", 17'(wdt_cnt), 17'h0);
    // a single restart, far from any other
    wr(8'h01, 8'h71);
    check("restarts", 17'(wdt_cnt), 17'h1);
    rd_chk(8'h01, 8'h31);
    wr(8'h01, 8'hc0);
    check("soft reset", outs, 17'h15204);
    rd_chk(8'h03, 8'h11);
    rd_chk(8'h01, 8'h3b);
    check("restarts", 17'(wdt_cnt), 17'h1);
    host.wr(7'h6a, 8'h02, 16'h00ff, 1, nack);
    check("address nack", nack, 1'b1);
    host.wr(`CCR_DEV_ADDR, 8'h08, 16'h00ff, 1, nack);
    check("register nack", nack, 1'b1);
    rd_chk(8'h02, 8'h20);
    // bursts: write pointer steps per byte, read pointer per host ack
    host.wr(`CCR_DEV_ADDR, 8'h06, 16'h5aa5, 2, nack);
    check("burst write ack", nack, 1'b0);
    host.rd(8'h06, 2, rd_val, nack);
    check("burst read ack", nack, 1'b0);
    check("burst read", rd_val, 16'h5aa5);
    // the byte after register 7 is refused, a read there gives zero
    host.wr(`CCR_DEV_ADDR, 8'h07, 16'h3cc3, 2, nack);
    check("past end nack", nack, 1'b1);
    host.rd(8'h07, 2, rd_val, nack);
    check("read past end", rd_val, 16'h3c00);
    wr(8'h02, 8'h9e);
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    tick(2);
    check("hard reset", outs, 17'h15204);
    summarize();
  end
endmodule // ccr_top_tb
